// ===== rtl/pes_event_decoder.sv
// Performance event source decoder: selects one programmable counter increment per cycle and forms the fixed and reference ones.
`timescale 1ns/1ps
module pes_event_decoder #(
   parameter int P_SAMPLE_CYCLES = pes_pkg::SAMPLE_CYCLES,
   parameter int P_BUS_RATIO     = pes_pkg::BUS_RATIO_DEF,
   parameter int P_MAX_OUTST     = pes_pkg::MAX_OUTST_DEF
) (
   input  wire logic                     I_MCLK,
   input  wire logic                     I_RESETN,
   input  wire logic [7:0]               I_EVENT_SEL,
   input  wire logic [7:0]               I_UNIT_MASK,
   input  wire logic                     I_L2_PENDING,
   input  wire logic                     I_PSTATE_DONE,
   input  wire logic                     I_FREQ_CHANGED,
   input  wire logic                     I_CORE_ACTIVE,
   input  wire logic                     I_TEMP_ABOVE_TRIP,
   input  wire logic                     I_HALT_EXEC,
   input  wire logic                     I_WAKE,
   input  wire logic                     I_OTHER_HALTED,
   input  wire logic                     I_CACHEABLE_RD,
   input  wire logic                     I_CACHEABLE_WR,
   input  wire logic                     I_LINE_READ_ISSUE,
   input  wire logic                     I_LINE_READ_DONE,
   output logic [pes_pkg::INC_W-1:0]     O_COUNT_INC,
   output logic                          O_FIXED_INC,
   output logic [pes_pkg::INC_W-1:0]     O_REF_INC,
   output logic                          O_THROTTLE,
   output logic                          O_BUS_TICK
);
   import pes_pkg::*;

   // Elaboration-time checks: the counters below cannot hold larger values.
   if (P_SAMPLE_CYCLES < 2 || P_SAMPLE_CYCLES >= (1 << 24))
   begin : g_bad_sample
      $error("P_SAMPLE_CYCLES out of range");
   end
   if (P_BUS_RATIO < 1 || P_BUS_RATIO > 255)
   begin : g_bad_ratio
      $error("P_BUS_RATIO out of range");
   end
   if (P_MAX_OUTST < 1 || P_MAX_OUTST > 255)
   begin : g_bad_outst
      $error("P_MAX_OUTST out of range");
   end

   localparam logic [23:0]      SAMPLE_LAST = 24'(P_SAMPLE_CYCLES - 1);
   localparam logic [7:0]       RATIO_LAST  = 8'(P_BUS_RATIO - 1);
   localparam logic [INC_W-1:0] RATIO_INC   = INC_W'(P_BUS_RATIO);
   localparam logic [INC_W-1:0] OUTST_MAX   = INC_W'(P_MAX_OUTST);

   function automatic logic sel_is(input logic [7:0] ev, input logic [7:0] um,
                                   input logic [7:0] ev_code, input logic [7:0] um_code);
      sel_is = (ev == ev_code) && (um == um_code);
   endfunction : sel_is

   logic                 temp_meta_reg;
   logic                 temp_sync_reg;
   logic                 temp_prev_reg;
   logic                 trip_rise;
   pes_therm_t           therm_reg;
   logic [23:0]          sample_cnt_reg;
   logic                 sample_tick;
   logic                 throttle_step;
   logic                 halted_reg;
   logic                 core_active;
   logic [7:0]           bus_div_reg;
   logic                 bus_tick;
   logic [INC_W-1:0]     outst_reg;
   logic [INC_W-1:0]     outst_seen;
   logic                 freq_event;
   logic [INC_W-1:0]     inc_next;

   // The temperature comparator is asynchronous to the core clock.
   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         temp_meta_reg <= 1'b0;
         temp_sync_reg <= 1'b0;
         temp_prev_reg <= 1'b0;
      end
      else
      begin
         temp_meta_reg <= I_TEMP_ABOVE_TRIP;
         temp_sync_reg <= temp_meta_reg;
         temp_prev_reg <= temp_sync_reg;
      end
   end

   assign trip_rise = temp_sync_reg && !temp_prev_reg;

   // Throttle control: a trip lowers frequency and voltage; recovery is checked once per sample period.
   assign sample_tick = (therm_reg == TH_THROTTLED) && (sample_cnt_reg == SAMPLE_LAST);

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         therm_reg      <= TH_NORMAL;
         sample_cnt_reg <= 24'h00_0000;
      end
      else
      begin
         case (therm_reg)
            TH_NORMAL:
            begin
               sample_cnt_reg <= 24'h00_0000;
               if (trip_rise)
                  therm_reg <= TH_THROTTLED;
            end
            TH_THROTTLED:
            begin
               if (sample_tick)
               begin
                  sample_cnt_reg <= 24'h00_0000;
                  if (!temp_sync_reg)
                     therm_reg <= TH_NORMAL;
               end
               else
                  sample_cnt_reg <= sample_cnt_reg + 24'h00_0001;
            end
            default:
            begin
               therm_reg      <= TH_NORMAL;
               sample_cnt_reg <= 24'h00_0000;
            end
         endcase
      end
   end

   assign O_THROTTLE    = (therm_reg == TH_THROTTLED);
   assign throttle_step = (therm_reg == TH_NORMAL && trip_rise) || (sample_tick && !temp_sync_reg);

   // Halt state: the cycle of the halt instruction already counts as halted.
   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
         halted_reg <= 1'b0;
      else if (I_HALT_EXEC)
         halted_reg <= 1'b1;
      else if (I_WAKE)
         halted_reg <= 1'b0;
   end

   assign core_active = !halted_reg && !I_HALT_EXEC;

   // Bus-clock rate as a one-cycle enable at the maximum core to bus ratio.
   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
         bus_div_reg <= 8'h00;
      else if (bus_div_reg == RATIO_LAST)
         bus_div_reg <= 8'h00;
      else
         bus_div_reg <= bus_div_reg + 8'h01;
   end

   assign bus_tick   = (bus_div_reg == RATIO_LAST);
   assign O_BUS_TICK = bus_tick;

   // Outstanding full-line reads; a read still counts in the cycle its last data arrives.
   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
         outst_reg <= INC_RST;
      else if (I_LINE_READ_ISSUE && !I_LINE_READ_DONE && outst_reg != OUTST_MAX)
         outst_reg <= outst_reg + INC_W'(1);
      else if (I_LINE_READ_DONE && !I_LINE_READ_ISSUE && outst_reg != INC_RST)
         outst_reg <= outst_reg - INC_W'(1);
   end

   assign outst_seen = outst_reg + INC_W'(I_LINE_READ_ISSUE);

   // Hardware-started steps are counted the same way as software-requested ones.
   assign freq_event = ((I_PSTATE_DONE && I_FREQ_CHANGED) || throttle_step) && I_CORE_ACTIVE;

   always_comb
   begin
      inc_next = INC_RST;
      if (I_EVENT_SEL == EV_L2_IDLE)
         inc_next = INC_W'(!I_L2_PENDING);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_FREQ_TRANS, UM_FREQ_TRANS))
         inc_next = INC_W'(freq_event);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_THERMAL, UM_THERMAL))
         inc_next = INC_W'(trip_rise);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_UNHALTED, UM_CORE))
         inc_next = INC_W'(core_active);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_UNHALTED, UM_BUS))
         inc_next = INC_W'(bus_tick && core_active);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_UNHALTED, UM_SOLE))
         inc_next = INC_W'(bus_tick && core_active && I_OTHER_HALTED);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_L1D, UM_RD))
         inc_next = INC_W'(I_CACHEABLE_RD);
      else if (sel_is(I_EVENT_SEL, I_UNIT_MASK, EV_L1D, UM_WR))
         inc_next = INC_W'(I_CACHEABLE_WR);
      else if (I_EVENT_SEL == EV_BUS_OUTST)
         inc_next = outst_seen;
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_COUNT_INC <= INC_RST;
         O_FIXED_INC <= 1'b0;
         O_REF_INC   <= INC_RST;
      end
      else
      begin
         O_COUNT_INC <= inc_next;
         O_FIXED_INC <= core_active;
         O_REF_INC   <= (bus_tick && core_active) ? RATIO_INC : INC_RST;
      end
   end

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RESETN);

   // Every increment appears one cycle after the signals that cause it; a thermal trip counts three cycles after I_TEMP_ABOVE_TRIP rises.
   a_l2_idle_count: assert property ((I_EVENT_SEL == EV_L2_IDLE && !I_L2_PENDING)
      |=> O_COUNT_INC == INC_W'(1))
      else $error("L2 idle cycle not counted");
   a_l2_busy: assert property ((I_EVENT_SEL == EV_L2_IDLE && I_L2_PENDING)
      |=> O_COUNT_INC == INC_RST)
      else $error("Busy L2 cycle counted");

   // Frequency transitions, requested by software or started by the thermal logic.
   a_freq_step: assert property ((I_EVENT_SEL == EV_FREQ_TRANS && I_UNIT_MASK == UM_FREQ_TRANS
      && I_CORE_ACTIVE && I_PSTATE_DONE && I_FREQ_CHANGED) |=> O_COUNT_INC == INC_W'(1))
      else $error("Frequency transition missed");
   a_freq_quiet: assert property ((I_EVENT_SEL == EV_FREQ_TRANS && I_UNIT_MASK == UM_FREQ_TRANS
      && !(I_PSTATE_DONE && I_FREQ_CHANGED) && !throttle_step) |=> O_COUNT_INC == INC_RST)
      else $error("Transition counted without a step");
   a_freq_only_c0: assert property ((I_EVENT_SEL == EV_FREQ_TRANS && I_UNIT_MASK == UM_FREQ_TRANS
      && !I_CORE_ACTIVE) |=> O_COUNT_INC == INC_RST)
      else $error("Transition counted outside active state");
   a_freq_hw: assert property ((I_EVENT_SEL == EV_FREQ_TRANS && I_UNIT_MASK == UM_FREQ_TRANS
      && I_CORE_ACTIVE && !O_THROTTLE && trip_rise) |=> O_COUNT_INC == INC_W'(1))
      else $error("Hardware transition missed");

   // Thermal trips and the throttle that follows them.
   a_trip_count: assert property ((I_EVENT_SEL == EV_THERMAL && I_UNIT_MASK == UM_THERMAL
      && $rose(temp_sync_reg)) |=> O_COUNT_INC == INC_W'(1))
      else $error("Thermal trip missed");
   a_trip_throttle: assert property ((!O_THROTTLE && $rose(temp_sync_reg)) |=> O_THROTTLE [*2])
      else $error("Trip did not throttle");
   a_throttle_hold: assert property ((O_THROTTLE && !sample_tick) |=> O_THROTTLE)
      else $error("Throttle left between samples");
   a_restore_cold: assert property ((sample_tick && !temp_sync_reg) |=> !O_THROTTLE)
      else $error("Throttle not released when cool");
   a_hot_hold: assert property ((sample_tick && temp_sync_reg) |=> O_THROTTLE)
      else $error("Throttle released while hot");
   a_sample_range: assert property (sample_cnt_reg <= SAMPLE_LAST)
      else $error("Sample counter overran its period");

   // Unhalted core and bus cycles.
   a_halt_now: assert property ((I_EVENT_SEL == EV_UNHALTED && I_UNIT_MASK == UM_CORE && I_HALT_EXEC)
      |=> O_COUNT_INC == INC_RST && !O_FIXED_INC)
      else $error("Halt cycle counted");
   a_wake_active: assert property ((halted_reg && I_WAKE && !I_HALT_EXEC) ##1 !I_HALT_EXEC
      |=> O_FIXED_INC)
      else $error("Core not counted after wake");
   a_fixed_match: assert property ((I_EVENT_SEL == EV_UNHALTED && I_UNIT_MASK == UM_CORE)
      |=> O_COUNT_INC == INC_W'(O_FIXED_INC))
      else $error("Fixed and programmable disagree");
   a_fixed_active: assert property ((!halted_reg && !I_HALT_EXEC) |=> O_FIXED_INC)
      else $error("Fixed counter missed an active cycle");
   a_bus_ratio: assert property ((I_EVENT_SEL == EV_UNHALTED && I_UNIT_MASK == UM_BUS)
      |=> O_REF_INC == (O_COUNT_INC == INC_W'(1) ? RATIO_INC : INC_RST))
      else $error("Reference ratio broken");
   a_bus_halted: assert property ((I_EVENT_SEL == EV_UNHALTED && I_UNIT_MASK == UM_BUS && !core_active)
      |=> O_COUNT_INC == INC_RST)
      else $error("Halted bus cycle counted");
   a_ref_idle: assert property ((!bus_tick || I_HALT_EXEC) |=> O_REF_INC == INC_RST)
      else $error("Reference cycles off the bus tick");
   a_sole_core: assert property ((I_EVENT_SEL == EV_UNHALTED && I_UNIT_MASK == UM_SOLE && !I_OTHER_HALTED)
      |=> O_COUNT_INC == INC_RST)
      else $error("Sole-core counted with other running");
   a_sole_tick: assert property ((I_EVENT_SEL == EV_UNHALTED && I_UNIT_MASK == UM_SOLE && !bus_tick)
      |=> O_COUNT_INC == INC_RST)
      else $error("Sole-core counted off the bus tick");

   // Cacheable data accesses.
   a_rd_count: assert property ((I_EVENT_SEL == EV_L1D && I_UNIT_MASK == UM_RD)
      |=> O_COUNT_INC == INC_W'($past(I_CACHEABLE_RD)))
      else $error("Cacheable read miscounted");
   a_wr_count: assert property ((I_EVENT_SEL == EV_L1D && I_UNIT_MASK == UM_WR)
      |=> O_COUNT_INC == INC_W'($past(I_CACHEABLE_WR)))
      else $error("Cacheable write miscounted");

   // Outstanding full-line reads.
   a_outst_sum: assert property ((I_EVENT_SEL == EV_BUS_OUTST && outst_reg == INC_RST
      && I_LINE_READ_ISSUE && !I_LINE_READ_DONE)
      ##1 (I_EVENT_SEL == EV_BUS_OUTST && !I_LINE_READ_ISSUE) |=> O_COUNT_INC == INC_W'(1))
      else $error("Outstanding read not held");
   a_outst_empty: assert property ((I_EVENT_SEL == EV_BUS_OUTST && outst_reg == INC_RST
      && !I_LINE_READ_ISSUE) |=> O_COUNT_INC == INC_RST)
      else $error("Idle bus counted as outstanding");
   a_outst_done: assert property ((I_EVENT_SEL == EV_BUS_OUTST && outst_reg == INC_W'(1)
      && I_LINE_READ_DONE && !I_LINE_READ_ISSUE) |=> O_COUNT_INC == INC_W'(1))
      else $error("Read dropped in its last data cycle");
   a_outst_limit: assert property (outst_reg <= OUTST_MAX)
      else $error("Outstanding count above its limit");

   // Undefined selections.
   a_undef_zero: assert property ((I_EVENT_SEL == EV_L1D && I_UNIT_MASK == 8'h00)
      |=> O_COUNT_INC == INC_RST)
      else $error("Undefined selection counted");
   a_undef_thermal: assert property ((I_EVENT_SEL == EV_THERMAL && I_UNIT_MASK != UM_THERMAL)
      |=> O_COUNT_INC == INC_RST)
      else $error("Undefined thermal mask counted");

   c_trip_cycle:  cover property (O_THROTTLE ##1 !O_THROTTLE);
   c_freq_hw:     cover property (I_CORE_ACTIVE && throttle_step);
   c_halt_wake:   cover property (I_HALT_EXEC ##[1:20] I_WAKE);
   c_two_outst:   cover property (outst_reg == INC_W'(2));
   c_sole_bus:    cover property (bus_tick && core_active && I_OTHER_HALTED);
endmodule : pes_event_decoder

// ===== rtl/pes_pkg.sv
// Constants shared by the performance event source decoder.
package pes_pkg;
   localparam logic [7:0]  EV_L2_IDLE     = 8'h32;
   localparam logic [7:0]  EV_FREQ_TRANS  = 8'h3A;
   localparam logic [7:0]  EV_THERMAL     = 8'h3B;
   localparam logic [7:0]  EV_UNHALTED    = 8'h3C;
   localparam logic [7:0]  EV_L1D         = 8'h40;
   localparam logic [7:0]  EV_BUS_OUTST   = 8'h60;
   localparam logic [7:0]  UM_FREQ_TRANS  = 8'h00;
   localparam logic [7:0]  UM_THERMAL     = 8'hC0;
   localparam logic [7:0]  UM_CORE        = 8'h00;
   localparam logic [7:0]  UM_BUS         = 8'h01;
   localparam logic [7:0]  UM_SOLE        = 8'h02;
   localparam logic [7:0]  UM_RD          = 8'h21;
   localparam logic [7:0]  UM_WR          = 8'h22;
   localparam int          INC_W          = 8;
   localparam logic [INC_W-1:0] INC_RST   = 8'h00;
   localparam int          CLK_PERIOD_PS  = 4000;
   localparam int          SAMPLE_MS      = 1;
   localparam int          SAMPLE_CYCLES  = (SAMPLE_MS * 1_000_000_000) / CLK_PERIOD_PS;
   localparam int          BUS_RATIO_DEF  = 4;
   localparam int          MAX_OUTST_DEF  = 8;
   typedef enum logic [0:0] {TH_NORMAL, TH_THROTTLED} pes_therm_t;
endpackage : pes_pkg

// ===== bench/pes_event_partner.sv
// Event sources facing the decoder: core, cache, power and bus strobes made from a random word.
`timescale 1ns/1ps
module pes_event_partner #(
   parameter int P_MAX_OUTST = 8
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [31:0] i_rnd,
   input  wire logic        i_hot,
   output logic      [11:0] o_ev
);
   int   outst;
   logic iss;
   logic dn;

   // Strobes change only on the falling edge, so the decoder always samples settled values.
   always @(negedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_ev  <= 12'h000;
         outst = 0;
      end
      else
      begin
         // The bus never holds more line reads than it can track, and none retires before issue.
         iss   = i_rnd[14] && (outst < P_MAX_OUTST - 1);
         dn    = i_rnd[15] && i_rnd[16] && (outst > 0);
         outst = outst + int'(iss) - int'(dn);
         o_ev  <= {dn, iss, i_rnd[13:11], i_rnd[10] & i_rnd[9], i_rnd[8] & i_rnd[7] & i_rnd[6],
                   i_hot, i_rnd[5] | i_rnd[4], i_rnd[3], i_rnd[2] & i_rnd[1], i_rnd[0]};
      end
   end
endmodule : pes_event_partner

// ===== bench/testbench.sv
// Self-checking bench for the performance event source decoder.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s: expected %0h, seen %0h", nm, ex, got); end end
module testbench;
   import pes_pkg::*;
   localparam int SMP = 16;
   localparam int RATIO = 4;
   localparam logic [15:0] COMBOS [15] = '{16'h3200, 16'h3255, 16'h3A00, 16'h3A01, 16'h3B00,
      16'h3C00, 16'h3C01, 16'h3C02, 16'h3C03, 16'h4021, 16'h4022, 16'h4023, 16'h6000, 16'h60FF, 16'h0000};
   logic             I_MCLK = 1'b0;
   logic             I_RESETN = 1'b0;
   logic [7:0]       sel = 8'h00;
   logic [7:0]       um = 8'h00;
   logic             hot = 1'b0;
   logic [31:0]      rnd = 32'hd2c0_604d;
   wire  [11:0]      ev;
   wire  [INC_W-1:0] cnt;
   wire  [INC_W-1:0] ref_inc;
   wire              fix;
   wire              thr;
   wire              tick;
   int               ph = -1;
   int               outst = 0;
   int               th_sum = 0;
   int               failures = 0;
   int               total_checks = 0;
   logic             halt_instruction = 1'b0;
   logic             v = 1'b0;
   logic             e_th = 1'b0;
   int               smp = 0;
   logic             h1 = 1'b0;
   logic             h2 = 1'b0;
   logic             h3 = 1'b0;
   logic             m_thr = 1'b0;
   logic             eh, act, pt, b, e_fix, rise, step;
   logic [7:0]       e_cnt, e_ref;

   always #2 I_MCLK = ~I_MCLK;

   function automatic logic [31:0] lfsr_step(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
   endfunction : lfsr_step

   always @(posedge I_MCLK) rnd <= lfsr_step(rnd);

   pes_event_partner #(.P_MAX_OUTST(MAX_OUTST_DEF)) u_src (.i_clk(I_MCLK), .i_resetn(I_RESETN), .i_rnd(rnd),
      .i_hot(hot), .o_ev(ev));

   pes_event_decoder #(.P_SAMPLE_CYCLES(SMP), .P_BUS_RATIO(RATIO), .P_MAX_OUTST(MAX_OUTST_DEF)) u_dut (
      .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_EVENT_SEL(sel), .I_UNIT_MASK(um), .I_L2_PENDING(ev[0]),
      .I_PSTATE_DONE(ev[1]), .I_FREQ_CHANGED(ev[2]), .I_CORE_ACTIVE(ev[3]), .I_TEMP_ABOVE_TRIP(ev[4]),
      .I_HALT_EXEC(ev[5]), .I_WAKE(ev[6]), .I_OTHER_HALTED(ev[7]), .I_CACHEABLE_RD(ev[8]),
      .I_CACHEABLE_WR(ev[9]), .I_LINE_READ_ISSUE(ev[10]), .I_LINE_READ_DONE(ev[11]), .O_COUNT_INC(cnt),
      .O_FIXED_INC(fix), .O_REF_INC(ref_inc), .O_THROTTLE(thr), .O_BUS_TICK(tick));

   // Reference model: works out the increments due for the inputs sampled at this edge.
   always @(posedge I_MCLK)
   begin
      if (I_RESETN)
      begin
         // The divider phase is not fixed, so the first tick sets it and later ticks must follow it.
         if (ph < 0 && tick) ph = 0;
         pt = (ph == 0);
         if (ph >= 0) `CHK("bus tick", pt, tick)
         // A halt counts at once; a wake takes effect from the next cycle.
         eh = ev[5] | (halt_instruction & !ev[6]);
         act = !(ev[5] | halt_instruction);
         v = (ph >= 0);
         // Trip detection two flops after the pin, then throttle entry and periodic exit steps.
         rise = h2 & !h3;
         step = (!m_thr & rise) | (m_thr & (smp == SMP - 1) & !h2);
         b = 1'b0;
         case ({sel, um})
            {EV_FREQ_TRANS, UM_FREQ_TRANS}: b = ((ev[1] & ev[2]) | step) & ev[3];
            {EV_THERMAL, UM_THERMAL}:       b = rise;
            {EV_UNHALTED, UM_CORE}:         b = act;
            {EV_UNHALTED, UM_BUS}:          b = act & pt;
            {EV_UNHALTED, UM_SOLE}:         b = act & pt & ev[7];
            {EV_L1D, UM_RD}:                b = ev[8];
            {EV_L1D, UM_WR}:                b = ev[9];
            default:                        b = 1'b0;
         endcase
         if (sel == EV_L2_IDLE) b = !ev[0];
         e_cnt = (sel == EV_BUS_OUTST) ? 8'(outst) + {7'h00, ev[10]} : {7'h00, b};
         e_th = ({sel, um} == {EV_THERMAL, UM_THERMAL});
         e_fix = act;
         e_ref = (act && pt) ? 8'(RATIO) : 8'h00;
         if (ev[10] && !ev[11]) outst++;
         else if (ev[11] && !ev[10] && outst > 0) outst--;
         if (ph >= 0) ph = (ph + 1) % RATIO;
         halt_instruction = eh;
         if (!m_thr)
         begin
            smp = 0;
            m_thr = rise;
         end
         else if (smp == SMP - 1)
         begin
            smp = 0;
            m_thr = h2;
         end
         else
            smp++;
         h3 = h2;
         h2 = h1;
         h1 = ev[4];
      end
   end

   always @(negedge I_MCLK)
   begin
      if (I_RESETN && v)
      begin
         if (e_th) th_sum += int'(cnt);
         `CHK("count", e_cnt, cnt)
         `CHK("throttle", m_thr, thr)
         `CHK("fixed", e_fix, fix)
         `CHK("reference", e_ref, ref_inc)
      end
   end

   task automatic results;
      $display("checks %0d, failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   initial
   begin
      repeat (20000) @(posedge I_MCLK);
      failures++;
      results();
   end

   initial
   begin
      repeat (12) @(posedge I_MCLK);
      @(negedge I_MCLK);
      I_RESETN = 1'b1;
      foreach (COMBOS[i])
      begin
         {sel, um} = COMBOS[i];
         repeat (300) @(negedge I_MCLK);
      end
      // Two trips counted as thermal events, a third seen as a hardware frequency transition.
      for (int k = 0; k < 3; k++)
      begin
         {sel, um} = (k < 2) ? {EV_THERMAL, UM_THERMAL} : {EV_FREQ_TRANS, UM_FREQ_TRANS};
         hot = 1'b1;
         repeat (40) @(negedge I_MCLK);
         `CHK("throttle on", 1'b1, thr)
         hot = 1'b0;
         repeat (2 * SMP + 8) @(negedge I_MCLK);
         `CHK("throttle off", 1'b0, thr)
      end
      `CHK("trips", 2, th_sum)
      results();
   end
endmodule : testbench
